// ### rtl/sroe_regs.sv
// soft reset and output enable registers of the tdm switch, with the pin enable stage
//
// Local design decision: strobed register access.
`timescale 1ns/100ps
module sroe_regs
    import sroe_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [sroe_pkg::SROE_ADDR_W-1:0] reg_addr,
    input wire logic [sroe_pkg::SROE_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [sroe_pkg::SROE_DATA_W-1:0] reg_rdata,
    input wire logic master_mode,
    input wire logic slave_loop_enable,
    input wire logic [sroe_pkg::SROE_NUM_CK-1:0] clock_src,
    input wire logic [sroe_pkg::SROE_NUM_FP-1:0] frame_pulse_src,
    input wire logic [sroe_pkg::SROE_OFS_W-1:0] offset_pulse_src,
    output logic switch_logic_reset_n,
    output logic loop_logic_reset_n,
    output logic [sroe_pkg::SROE_NUM_CK-1:0] clock_out,
    output logic [sroe_pkg::SROE_NUM_CK-1:0] clock_out_oe,
    output logic [sroe_pkg::SROE_NUM_FP-1:0] frame_pulse_out,
    output logic [sroe_pkg::SROE_NUM_FP-1:0] frame_pulse_out_oe,
    output logic [sroe_pkg::SROE_OFS_W-1:0] offset_frame_pulse,
    output logic [sroe_pkg::SROE_OFS_W-1:0] offset_frame_pulse_oe
);
    import sroe_pkg::*;

    // behaviour notes for whoever picks this block up next:
    // - both registers store all sixteen bits, reserved ones included, so a read
    //   returns exactly the last word written; nothing is masked on the way in.
    // - software that sets reserved bits gets them back on read but they steer nothing,
    //   which keeps the read path a plain copy at the cost of not flagging misuse.
    // - a write loads its register on the strobe edge; the reset controls and the
    //   pin enables follow one edge later, because every output leaves from a flop.
    // - reading a register in the cycle right after writing it already shows the new word.
    // - the reset controls are active low and come out of hardware reset asserted,
    //   so the switch and the loop stay held until software sets their bits.
    // - clocks four and five are generated by the loop; while neither master mode nor
    //   the slave loop is on, their pins stay released whatever their enable bits say.
    //   the enable bits themselves still read back as written.
    // - clocks zero..three share one enable with the frame pulse of the same number.
    // - the offset frame pulses take enable bits six, seven and eight in order.
    // - a released pin keeps following its source level inside the pin stage, so the
    //   first level driven after enabling is current rather than stale.
    // - the mode inputs come from logic on this same clock and are used unsynchronised;
    //   a mode change shows on the loop clock enables one edge later.
    // - the register port never waits: read data stand in the cycle after the strobe
    //   and fall back to zero in every other cycle, so no holding register is needed.

    // stored register words and their next values
    sroe_word_t software_reset_control;
    sroe_word_t output_clock_pulse_enable;
    sroe_word_t next_software_reset_control;
    sroe_word_t next_output_clock_pulse_enable;
    // next levels of the two reset controls
    logic next_switch_logic_reset_n;
    logic next_loop_logic_reset_n;
    // decoded strobes, one per register and direction
    logic sw_reset_wr_hit;
    logic out_en_wr_hit;
    logic sw_reset_rd_hit;
    logic out_en_rd_hit;
    // enable of every output enable field after the mode gate
    wire [SROE_OFS_LSB+SROE_OFS_W-1:0] field_en;
    logic loop_clocks_ok;
    // per-pin vectors, before and after the pin stage flops
    wire [SROE_NUM_PINS-1:0] pin_en_map;
    wire [SROE_NUM_PINS-1:0] pin_src_map;
    logic [SROE_NUM_PINS-1:0] pin_out;
    logic [SROE_NUM_PINS-1:0] pin_oe;
    sroe_word_t next_rdata;

    sroe_pin_if pins ();

    // address decode; the port has no byte lanes, so an exact index match selects a register
    assign sw_reset_wr_hit = reg_wr && (reg_addr == SROE_SW_RESET_OFS);
    assign out_en_wr_hit = reg_wr && (reg_addr == SROE_OUT_EN_OFS);
    assign sw_reset_rd_hit = reg_rd && (reg_addr == SROE_SW_RESET_OFS);
    assign out_en_rd_hit = reg_rd && (reg_addr == SROE_OUT_EN_OFS);

    // next value of the software reset register; a write replaces the whole word
    always_comb
    begin
        next_software_reset_control = software_reset_control;
        if (sw_reset_wr_hit)
        begin
            next_software_reset_control = reg_wdata;
        end
    end

    // software reset register; every bit is kept so a read returns what was written
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            software_reset_control <= SROE_SW_RESET_RST;
        end
        else
        begin
            software_reset_control <= next_software_reset_control;
        end
    end

    // next value of the output enable register; reserved bits are stored as written
    always_comb
    begin
        next_output_clock_pulse_enable = output_clock_pulse_enable;
        if (out_en_wr_hit)
        begin
            next_output_clock_pulse_enable = reg_wdata;
        end
    end

    // output enable register; reserved bits are stored too, software keeps them at zero
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            output_clock_pulse_enable <= SROE_OUT_EN_RST;
        end
        else
        begin
            output_clock_pulse_enable <= next_output_clock_pulse_enable;
        end
    end

    // next levels of the reset controls, taken straight from their register bits
    always_comb
    begin
        next_switch_logic_reset_n = software_reset_control[SROE_SWITCH_RST_BIT];
        next_loop_logic_reset_n = software_reset_control[SROE_LOOP_RST_BIT];
    end

    // switching logic reset; flopped so the released logic never sees a decode glitch
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            switch_logic_reset_n <= 1'h0;
        end
        else
        begin
            switch_logic_reset_n <= next_switch_logic_reset_n;
        end
    end

    // loop logic reset; held low from hardware reset until software sets its bit
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            loop_logic_reset_n <= 1'h0;
        end
        else
        begin
            loop_logic_reset_n <= next_loop_logic_reset_n;
        end
    end

    // read select: an unmapped or idle cycle gives zero, so the data stand one cycle only
    always_comb
    begin
        next_rdata = SROE_READ_ZERO;
        if (sw_reset_rd_hit)
        begin
            next_rdata = software_reset_control;
        end
        else if (out_en_rd_hit)
        begin
            next_rdata = output_clock_pulse_enable;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            reg_rdata <= SROE_READ_ZERO;
        end
        else
        begin
            reg_rdata <= next_rdata;
        end
    end

    // clocks four and five only exist when the loop generates them
    assign loop_clocks_ok = master_mode | slave_loop_enable;

    // one enable per register field; only the two loop clocks carry the mode gate
    genvar fi;
    generate
        for (fi = 0; fi < SROE_OFS_LSB + SROE_OFS_W; fi++)
        begin : g_field
            if (fi == SROE_CK4_BIT)
            begin : g_ck4
                // the bit still reads back as set while the clock is unavailable
                assign field_en[fi] = output_clock_pulse_enable[fi] & loop_clocks_ok;
            end
            else if (fi == SROE_CK5_BIT)
            begin : g_ck5
                assign field_en[fi] = output_clock_pulse_enable[fi] & loop_clocks_ok;
            end
            else if (fi >= SROE_OFS_LSB)
            begin : g_ofs
                assign field_en[fi] = output_clock_pulse_enable[fi];
            end
            else
            begin : g_ckfp
                assign field_en[fi] = output_clock_pulse_enable[fi];
            end
        end
    endgenerate

    // route each pin to its field enable and to its source level
    genvar pi;
    generate
        for (pi = 0; pi < SROE_NUM_PINS; pi++)
        begin : g_map
            if (pi < SROE_PIN_FP_LSB)
            begin : g_clk
                // clock pins zero..five follow fields zero..five one to one
                assign pin_en_map[pi] = field_en[pi];
                assign pin_src_map[pi] = clock_src[pi];
            end
            else if (pi < SROE_PIN_OFS_LSB)
            begin : g_fp
                // a frame pulse pin shares the field of the clock with the same number
                assign pin_en_map[pi] = field_en[SROE_CKFP_LSB + pi - SROE_PIN_FP_LSB];
                assign pin_src_map[pi] = frame_pulse_src[pi - SROE_PIN_FP_LSB];
            end
            else
            begin : g_ofs
                // offset pulse pins take the three top fields in order
                assign pin_en_map[pi] = field_en[SROE_OFS_LSB + pi - SROE_PIN_OFS_LSB];
                assign pin_src_map[pi] = offset_pulse_src[pi - SROE_PIN_OFS_LSB];
            end
        end
    endgenerate

    // hand the mapped vectors to the pin stage through the carrier
    assign pins.pin_en = pin_en_map;
    assign pins.pin_src = pin_src_map;

    sroe_pin_stage u_pin_stage (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .pins(pins),
        .pin_out(pin_out),
        .pin_oe(pin_oe)
    );

    // split the flopped pin vector back into the named pin groups
    assign clock_out = pin_out[SROE_NUM_CK-1:0];
    assign clock_out_oe = pin_oe[SROE_NUM_CK-1:0];
    assign frame_pulse_out = pin_out[SROE_PIN_FP_LSB +: SROE_NUM_FP];
    assign frame_pulse_out_oe = pin_oe[SROE_PIN_FP_LSB +: SROE_NUM_FP];
    assign offset_frame_pulse = pin_out[SROE_PIN_OFS_LSB +: SROE_OFS_W];
    assign offset_frame_pulse_oe = pin_oe[SROE_PIN_OFS_LSB +: SROE_OFS_W];
endmodule

// ### rtl/sroe_pkg.sv
// package: register map, field positions and reset values of the soft reset and output enable registers
package sroe_pkg;
    localparam int SROE_DATA_W = 16;
    localparam int SROE_ADDR_W = 16;

    typedef logic [SROE_DATA_W-1:0] sroe_word_t;
    typedef logic [SROE_ADDR_W-1:0] sroe_addr_t;

    // register offsets, in register index units of the plain port
    localparam sroe_addr_t SROE_SW_RESET_OFS = 16'h0002;
    localparam sroe_addr_t SROE_OUT_EN_OFS = 16'h0003;

    // reset values
    localparam sroe_word_t SROE_SW_RESET_RST = 16'h0000;
    localparam sroe_word_t SROE_OUT_EN_RST = 16'h0000;
    localparam sroe_word_t SROE_READ_ZERO = 16'h0000;

    // software reset register fields (low holds the logic in reset)
    localparam int SROE_LOOP_RST_BIT = 0;
    localparam int SROE_SWITCH_RST_BIT = 1;

    // output enable register fields
    localparam int SROE_CKFP_LSB = 0;
    localparam int SROE_CKFP_W = 4;
    localparam int SROE_CK4_BIT = 4;
    localparam int SROE_CK5_BIT = 5;
    localparam int SROE_OFS_LSB = 6;
    localparam int SROE_OFS_W = 3;

    // pin count driven by the pin stage: 6 clocks, 4 frame pulses, 3 offset pulses
    localparam int SROE_NUM_CK = 6;
    localparam int SROE_NUM_FP = 4;
    localparam int SROE_NUM_PINS = SROE_NUM_CK + SROE_NUM_FP + SROE_OFS_W;
    localparam int SROE_PIN_FP_LSB = SROE_NUM_CK;
    localparam int SROE_PIN_OFS_LSB = SROE_NUM_CK + SROE_NUM_FP;
endpackage

// ### rtl/sroe_pin_if.sv
// interface: per-pin enables and source levels handed from the register block to the pin stage
`timescale 1ns/100ps
interface sroe_pin_if;
    import sroe_pkg::*;
    logic [SROE_NUM_PINS-1:0] pin_en;
    logic [SROE_NUM_PINS-1:0] pin_src;

    modport ctrl (output pin_en, output pin_src);
    modport stage (input pin_en, input pin_src);
endinterface

// ### rtl/sroe_pin_stage.sv
// pin stage: registered level and output enable for every clock and frame pulse pin
`timescale 1ns/100ps
module sroe_pin_stage
    import sroe_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    sroe_pin_if.stage pins,
    output logic [sroe_pkg::SROE_NUM_PINS-1:0] pin_out,
    output logic [sroe_pkg::SROE_NUM_PINS-1:0] pin_oe
);
    // one flop pair per pin; the enable lags the register write by one cycle
    genvar gi;
    generate
        for (gi = 0; gi < SROE_NUM_PINS; gi++)
        begin : g_pin
            always_ff @(posedge core_clk or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    pin_oe[gi] <= 1'h0;
                    pin_out[gi] <= 1'h0;
                end
                else
                begin
                    pin_oe[gi] <= pins.pin_en[gi];
                    // a released pin still carries the source, so it is clean when re-enabled
                    pin_out[gi] <= pins.pin_src[gi];
                end
            end
        end
    endgenerate
endmodule

// ### dv/sroe_regs_asserts.sv
// checker: port assertions of the soft reset and output enable block
`timescale 1ns/100ps
module sroe_regs_asserts
    import sroe_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic master_mode,
    input wire logic slave_loop_enable,
    input wire logic [5:0] clock_src,
    input wire logic [5:0] clock_out,
    input wire logic [5:0] clock_out_oe,
    input wire logic [3:0] frame_pulse_out_oe,
    input wire logic [2:0] offset_frame_pulse_oe,
    input wire logic switch_logic_reset_n,
    input wire logic loop_logic_reset_n
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // decoded writes; a write loads on its edge and reaches the outputs one edge later
    wire w_rst = reg_wr && reg_addr == SROE_SW_RESET_OFS;
    wire w_oe = reg_wr && reg_addr == SROE_OUT_EN_OFS;
    property p_rst; w_rst |-> ##2 {switch_logic_reset_n, loop_logic_reset_n} == $past(reg_wdata[1:0], 2); endproperty
    a_rst: assert property (p_rst) else $error("reset control lags write");
    property p_ckfp; w_oe |-> ##2 {clock_out_oe[3:0], frame_pulse_out_oe} == {2{$past(reg_wdata[3:0], 2)}}; endproperty
    a_ckfp: assert property (p_ckfp) else $error("clock and pulse enables wrong");
    property p_ofs; w_oe |-> ##2 offset_frame_pulse_oe == $past(reg_wdata[8:6], 2); endproperty
    a_ofs: assert property (p_ofs) else $error("offset pulse enables wrong");
    property p_ck45; w_oe && master_mode ##1 master_mode |=> clock_out_oe[5:4] == $past(reg_wdata[5:4], 2); endproperty
    a_ck45: assert property (p_ck45) else $error("clock four or five enable wrong");
    // the upper clocks stay off unless some mode allows them, whatever the bits say
    property p_gate; !(master_mode || slave_loop_enable) |=> clock_out_oe[5:4] == 2'h0; endproperty
    a_gate: assert property (p_gate) else $error("clock four or five driven while unavailable");
    property p_back; w_oe ##1 reg_rd && reg_addr == SROE_OUT_EN_OFS |=> reg_rdata == $past(reg_wdata, 2); endproperty
    a_back: assert property (p_back) else $error("read back differs from write");
    property p_idle; !(reg_rd && (w_rst | w_oe | reg_addr == SROE_SW_RESET_OFS | reg_addr == SROE_OUT_EN_OFS))
        |=> reg_rdata == 16'h0000; endproperty
    a_idle: assert property (p_idle) else $error("read data without a mapped read");
    property p_pin; $past(rst_b) |-> clock_out == $past(clock_src); endproperty
    a_pin: assert property (p_pin) else $error("clock pin level does not follow source");
endmodule

bind sroe_regs sroe_regs_asserts u_chk (.*);

// ### dv/test_sroe_regs.sv
// testbench: register access and pin enable checks of the soft reset and output enable block
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; \
    $display("wrong value at %0t: got %h want %h", $time, g, e); end end
module test_sroe_regs;
    import sroe_pkg::*;
    logic core_clk = 1'h0, rst_b = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, master_mode = 1'h0, slave_loop_enable = 1'h0;
    sroe_addr_t reg_addr = 16'h0000;
    sroe_word_t reg_wdata = 16'h0000, reg_rdata, d;
    logic [5:0] clock_src = 6'h00, clock_out, clock_out_oe;
    logic [3:0] frame_pulse_src = 4'h0, frame_pulse_out, frame_pulse_out_oe;
    logic [2:0] offset_pulse_src = 3'h0, offset_frame_pulse, offset_frame_pulse_oe;
    logic switch_logic_reset_n, loop_logic_reset_n;
    int errors = 0, n_tests = 0;
    sroe_regs DUT (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .master_mode(master_mode),
        .slave_loop_enable(slave_loop_enable),
        .clock_src(clock_src),
        .frame_pulse_src(frame_pulse_src),
        .offset_pulse_src(offset_pulse_src),
        .switch_logic_reset_n(switch_logic_reset_n),
        .loop_logic_reset_n(loop_logic_reset_n),
        .clock_out(clock_out),
        .clock_out_oe(clock_out_oe),
        .frame_pulse_out(frame_pulse_out),
        .frame_pulse_out_oe(frame_pulse_out_oe),
        .offset_frame_pulse(offset_frame_pulse),
        .offset_frame_pulse_oe(offset_frame_pulse_oe)
    );
    always #50 core_clk = ~core_clk;
    // tasks start and end on a rising edge, so a write may be followed at once by a read
    task automatic wr(input sroe_addr_t a, input sroe_word_t v);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge core_clk);
        reg_wr <= 1'h0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input sroe_addr_t a, input sroe_word_t v);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'h0;
        #1;
        `CHK(reg_rdata, v)
        @(posedge core_clk);
    endtask
    task automatic close_out;
        $display("errors %0d in %0d checks", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // watchdog: the sequence needs well under a thousand cycles
    initial
    begin
        #100000;
        errors++;
        close_out();
    end
    initial
    begin
        repeat (12) @(posedge core_clk);
        rst_b <= 1'h1;
        master_mode <= 1'h1;
        rd(SROE_SW_RESET_OFS, 16'h0000);
        `CHK({switch_logic_reset_n, loop_logic_reset_n, clock_out_oe, frame_pulse_out_oe, offset_frame_pulse_oe}, 15'h0)
        // walk one enable bit at a time through the whole field, reserved bits kept at zero
        for (int i = 0; i < 9; i++)
        begin
            d = 16'h0001 << i;
            wr(SROE_OUT_EN_OFS, d);
            rd(SROE_OUT_EN_OFS, d);
            `CHK({offset_frame_pulse_oe, clock_out_oe, frame_pulse_out_oe}, {d[8:0], d[3:0]})
        end
        master_mode <= 1'h0;
        wr(SROE_OUT_EN_OFS, 16'h0030);
        rd(SROE_OUT_EN_OFS, 16'h0030);
        `CHK(clock_out_oe, 6'h00)
        slave_loop_enable <= 1'h1;
        rd(SROE_OUT_EN_OFS, 16'h0030);
        `CHK(clock_out_oe, 6'h30)
        for (int i = 0; i < 4; i++)
        begin
            wr(SROE_SW_RESET_OFS, 16'(i));
            rd(SROE_SW_RESET_OFS, 16'(i));
            `CHK({switch_logic_reset_n, loop_logic_reset_n}, 2'(i))
        end
        // unmapped place: write ignored, read gives zero
        wr(16'h0004, 16'h0001);
        rd(16'h0004, 16'h0000);
        clock_src <= 6'h2A;
        frame_pulse_src <= 4'h5;
        offset_pulse_src <= 3'h6;
        rd(SROE_SW_RESET_OFS, 16'h0003);
        `CHK({clock_out, frame_pulse_out, offset_frame_pulse}, {6'h2A, 4'h5, 3'h6})
        rst_b <= 1'h0;
        @(posedge core_clk);
        rst_b <= 1'h1;
        rd(SROE_OUT_EN_OFS, 16'h0000);
        `CHK({switch_logic_reset_n, loop_logic_reset_n, clock_out_oe}, 8'h00)
        close_out();
    end
endmodule
